// >>> design/bfrm_pkg.sv
// bfrm_pkg: register map constants for the fieldbus expansion register bank
// assumes a modbus frame engine outside decodes frames into register strobes
package bfrm_pkg;
    localparam int          REG_AW            = 16;
    localparam int          REG_DW            = 16;
    localparam logic [7:0]  FC_READ_DISCRETE  = 8'h02;
    localparam logic [7:0]  FC_READ_INPUT     = 8'h04;
    localparam logic [7:0]  FC_WRITE_COIL     = 8'h05;
    localparam logic [7:0]  FC_WRITE_REG      = 8'h06;
    localparam logic [7:0]  FC_WRITE_MULTI    = 8'h10;
    localparam logic [7:0]  EXC_ILLEGAL_FUNC  = 8'h01;
    localparam logic [7:0]  EXC_ILLEGAL_ADDR  = 8'h02;
    localparam logic [15:0] COIL_ON           = 16'hFF00;
    localparam logic [15:0] COIL_OFF          = 16'h0000;
    // holding registers
    localparam logic [15:0] ADDR_CTRL         = 16'h0000;
    localparam logic [15:0] ADDR_SETPOINT     = 16'h0001;
    // input registers
    localparam logic [15:0] ADDR_HW_INPUTS    = 16'h0000;
    localparam logic [15:0] ADDR_SERIAL_LO    = 16'h0034;
    localparam logic [15:0] ADDR_SERIAL_HI    = 16'h0035;
    localparam logic [15:0] ADDR_HWART_LO     = 16'h0036;
    localparam logic [15:0] ADDR_HWART_HI     = 16'h0037;
    localparam logic [15:0] ADDR_ART_LO       = 16'h0038;
    localparam logic [15:0] ADDR_ART_HI       = 16'h0039;
    localparam logic [15:0] ADDR_ERR_STATE    = 16'h003A;
    localparam logic [15:0] ADDR_IN_FUNC      = 16'h003B;
    localparam logic [15:0] ADDR_TEMP         = 16'h003C;
    localparam logic [15:0] ADDR_FAN_LO       = 16'h003D;
    localparam logic [15:0] ADDR_FAN_HI       = 16'h003E;
    localparam logic [15:0] ADDR_SPARE        = 16'h003F;
    localparam int          DI_BITS           = 4;
    // control bits
    localparam int          CB_HEAT           = 0;
    localparam int          CB_STEP_PURGE     = 1;
    localparam int          CB_UNLOCK         = 2;
    localparam int          CB_AUX            = 3;
    localparam int          CB_COOL           = 4;
    localparam int          CB_MAIN           = 5;
    localparam int          CB_START          = 6;
    localparam int          CB_PWR_EN         = 8;
    localparam int          CB_PWR_UP         = 9;
    localparam int          CB_PWR_DN         = 10;
    localparam int          CB_ABS            = 11;
    localparam logic [15:0] CTRL_MASK         = 16'h0F7F;
    localparam logic [15:0] CTRL_RESET        = 16'h0000;
    localparam logic [15:0] SETPOINT_RESET    = 16'h0000;
    localparam logic [3:0]  AUX_CFG_BUS       = 4'h8;
    // temperature
    localparam logic [7:0]  TEMP_OFFSET       = 8'h32;
    localparam logic [7:0]  TEMP_WARN_C       = 8'h52;
    // identity, arbitrary neutral values
    localparam logic [31:0] SERIAL_DEFAULT    = 32'h0000_0001;
    localparam logic [23:0] HWART_DEFAULT     = 24'h000001;
    localparam logic [7:0]  HWREV_DEFAULT     = 8'h01;
    localparam logic [23:0] ART_DEFAULT       = 24'h000002;
    localparam logic [7:0]  ARTREV_DEFAULT    = 8'h01;
    // synchroniser depth; a new flag must hold on the pins for two cycles to count
    localparam int          SYNC_STAGES       = 3;
endpackage

// >>> design/bfrm_sync.sv
// bfrm_sync: three-stage synchroniser bank for asynchronous pin inputs
// assumes inputs are quasi-static compared with the 40 MHz clock
`timescale 1ns/10ps
module bfrm_sync #(
    parameter int W = 1
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_resetn,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta <= '0;
            s2   <= '0;
            s3   <= '0;
        end else begin
            meta <= i_async;
            s2   <= meta;
            s3   <= s2;
        end
    end

    // change accepted only once stages two and three agree
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sync <= '0;
        end else begin
            for (int k = 0; k < W; k++) begin
                if (s2[k] == s3[k]) begin
                    o_sync[k] <= s3[k];
                end
            end
        end
    end
endmodule

// >>> design/bfrm_regs.sv
// bfrm_regs: modbus register bank of the burner fieldbus expansion module
// assumes an external frame engine presents one register access per strobe
// Functional notes
// - serial number spans two input registers, least significant byte first.
// - hardware article number low byte first, revision in high byte.
// - module article number low byte first, revision in high byte.
// - error register low byte holds state active at last error.
// - input status bits 0..7 mirror the eight hardware input functions.
// - bit 8 air switch wrong in cooling, bit 12 wrong in purge.
// - bit 9 auxiliary output state outside lockout, bit 11 second air pressure input.
// - bit 10 warns when housing temperature exceeds high threshold.
// - temperature register low byte is celsius plus offset fifty.
// - fan output switching cycles counted in 32 bits over two registers.
// - write coil, write register and write multiple are accepted.
// - read input registers and read discrete inputs are answered.
// - control bits 0,1,2,4,5,6 act as burner commands.
// - auxiliary output follows control bit 3 only when config equals 8.
// - with bit 8 set, bit 9 raises and bit 10 lowers power.
// - bit 11 takes absolute setpoint from register 1 in half percent.
// - digital input register bits 0..3 show more, less, high, low.
`timescale 1ns/10ps
module bfrm_regs
    import bfrm_pkg::*;
(
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_resetn,
    // register access from the frame engine
    input  wire logic                  i_req,
    input  wire logic [7:0]            i_func,
    input  wire logic [15:0]           i_addr,
    input  wire logic [15:0]           i_wdata,
    output logic                       o_ack,
    output logic                       o_exc,
    output logic [7:0]                 o_exc_code,
    output logic [15:0]                o_rdata,
    // device state
    input  wire logic                  i_lockout,
    input  wire logic [7:0]            i_error_state,
    input  wire logic [7:0]            i_input_funcs,
    input  wire logic                  i_air_wrong_cool,
    input  wire logic                  i_air_wrong_purge,
    input  wire logic                  i_second_air_pressure_input,
    input  wire logic [7:0]            i_temp_celsius,
    input  wire logic [3:0]            i_aux_output_config_param,
    input  wire logic [DI_BITS-1:0]    i_heat_inputs,
    input  wire logic                  i_cooling_fan_output,
    // commands
    output logic                       o_heat_request,
    output logic                       o_step_or_purge,
    output logic                       o_remote_unlock,
    output logic                       o_cooling_on,
    output logic                       o_main_burner_on,
    output logic                       o_start_release,
    output logic                       o_auxiliary_output,
    output logic                       o_power_up,
    output logic                       o_power_down,
    output logic                       o_abs_enable,
    output logic [15:0]                o_abs_setpoint
);
    logic [15:0]        ctrl;
    logic [15:0]        setpoint;
    logic [31:0]        fan_count;
    logic               fan_prev;
    logic [DI_BITS-1:0] di_sync;
    logic               fan_sync;
    logic               func_ok;
    logic               is_write;
    logic               addr_ok;
    logic [15:0]        next_rdata;
    logic [15:0]        in_status;

    // assertions without their own clock share the bank clock and reset
    default clocking cb_sys @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_resetn);

    bfrm_sync #(.W(DI_BITS + 1)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_async   ({i_cooling_fan_output, i_heat_inputs}),
        .o_sync    ({fan_sync, di_sync})
    );

    function automatic logic [15:0] coil_mask(input logic [15:0] a);
        coil_mask = 16'h0001 << a[3:0];
    endfunction

    // only the five documented function codes are served
    always_comb begin
        func_ok  = (i_func == FC_READ_DISCRETE) || (i_func == FC_READ_INPUT) ||
                   (i_func == FC_WRITE_COIL) || (i_func == FC_WRITE_REG) || (i_func == FC_WRITE_MULTI);
        is_write = (i_func == FC_WRITE_COIL) || (i_func == FC_WRITE_REG) || (i_func == FC_WRITE_MULTI);
    end

    always_comb begin
        in_status        = 16'h0000;
        in_status[7:0]   = i_input_funcs;
        in_status[8]     = i_air_wrong_cool;
        in_status[9]     = o_auxiliary_output & ~i_lockout;
        in_status[10]    = i_temp_celsius > TEMP_WARN_C;
        in_status[11]    = i_second_air_pressure_input;
        in_status[12]    = i_air_wrong_purge;
    end

    always_comb begin
        addr_ok    = 1'b1;
        next_rdata = 16'h0000;
        if (i_func == FC_READ_DISCRETE) begin
            // discrete inputs are the low bits of input register 0
            addr_ok    = i_addr < 16'(DI_BITS);
            next_rdata = {15'h0000, di_sync[i_addr[1:0]]};
        end else if (i_func == FC_WRITE_COIL) begin
            addr_ok = (i_addr < 16'(REG_DW)) && ((i_wdata == COIL_ON) || (i_wdata == COIL_OFF));
        end else if (is_write) begin
            addr_ok = (i_addr == ADDR_CTRL) || (i_addr == ADDR_SETPOINT);
        end else begin
            unique case (i_addr)
                ADDR_HW_INPUTS: next_rdata = {12'h000, di_sync};
                ADDR_SERIAL_LO: next_rdata = SERIAL_DEFAULT[15:0];
                ADDR_SERIAL_HI: next_rdata = {i_lockout ? 8'h00 : SERIAL_DEFAULT[31:24],
                                              SERIAL_DEFAULT[23:16]};
                ADDR_HWART_LO:  next_rdata = HWART_DEFAULT[15:0];
                ADDR_HWART_HI:  next_rdata = {HWREV_DEFAULT, HWART_DEFAULT[23:16]};
                ADDR_ART_LO:    next_rdata = ART_DEFAULT[15:0];
                ADDR_ART_HI:    next_rdata = {ARTREV_DEFAULT, ART_DEFAULT[23:16]};
                ADDR_ERR_STATE: next_rdata = {8'h00, i_error_state};
                ADDR_IN_FUNC:   next_rdata = in_status;
                ADDR_TEMP:      next_rdata = {8'h00, 8'(i_temp_celsius + TEMP_OFFSET)};
                ADDR_FAN_LO:    next_rdata = fan_count[15:0];
                ADDR_FAN_HI:    next_rdata = fan_count[31:16];
                ADDR_SPARE:     next_rdata = 16'h0000;
                default:        addr_ok    = 1'b0;
            endcase
        end
    end

    // one-cycle answer for every request; exception codes follow modbus
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ack      <= 1'b0;
            o_exc      <= 1'b0;
            o_exc_code <= 8'h00;
            o_rdata    <= 16'h0000;
        end else begin
            o_ack      <= i_req;
            o_exc      <= i_req && !(func_ok && addr_ok);
            o_exc_code <= !i_req ? 8'h00 : (!func_ok ? EXC_ILLEGAL_FUNC : (!addr_ok ? EXC_ILLEGAL_ADDR : 8'h00));
            o_rdata    <= (i_req && func_ok && addr_ok && !is_write) ? next_rdata : 16'h0000;
        end
    end

    // control writes; unused bits never stored so they stay zero in ctrl
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl     <= CTRL_RESET;
            setpoint <= SETPOINT_RESET;
        end else if (i_req && func_ok && addr_ok && is_write) begin
            if (i_func == FC_WRITE_COIL) begin
                if (i_wdata == COIL_ON) begin
                    ctrl <= (ctrl | coil_mask(i_addr)) & CTRL_MASK;
                end else begin
                    ctrl <= ctrl & ~coil_mask(i_addr);
                end
            end else if (i_addr == ADDR_CTRL) begin
                ctrl <= i_wdata & CTRL_MASK;
            end else begin
                setpoint <= i_wdata;
            end
        end
    end

    // rising edges of the fan output; wraps silently at 2^32
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fan_prev  <= 1'b0;
            fan_count <= 32'h0000_0000;
        end else begin
            fan_prev <= fan_sync;
            if (fan_sync && !fan_prev) begin
                fan_count <= fan_count + 32'h0000_0001;
            end
        end
    end

    // power up/down exclusive so a double command means hold
    always_comb begin
        o_heat_request     = ctrl[CB_HEAT];
        o_step_or_purge    = ctrl[CB_STEP_PURGE];
        o_remote_unlock    = ctrl[CB_UNLOCK];
        o_cooling_on       = ctrl[CB_COOL];
        o_main_burner_on   = ctrl[CB_MAIN];
        o_start_release    = ctrl[CB_START];
        o_auxiliary_output = ctrl[CB_AUX] && (i_aux_output_config_param == AUX_CFG_BUS);
        o_power_up         = ctrl[CB_PWR_EN] && ctrl[CB_PWR_UP] && !ctrl[CB_PWR_DN];
        o_power_down       = ctrl[CB_PWR_EN] && ctrl[CB_PWR_DN] && !ctrl[CB_PWR_UP];
        o_abs_enable       = ctrl[CB_ABS];
        o_abs_setpoint     = ctrl[CB_ABS] ? setpoint : 16'h0000;
    end

    property p_ack_follows;
        @(posedge i_sys_clk) disable iff (!i_resetn) i_req |=> o_ack;
    endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("no answer after request");

    property p_bad_func;
        @(posedge i_sys_clk) disable iff (!i_resetn)
            (i_req && !func_ok) |=> (o_exc && o_exc_code == EXC_ILLEGAL_FUNC);
    endproperty
    a_bad_func: assert property (p_bad_func) else $error("bad function not refused");

    property p_ctrl_write;
        @(posedge i_sys_clk) disable iff (!i_resetn)
            (i_req && i_func == FC_WRITE_REG && i_addr == ADDR_CTRL) |=> (ctrl == ($past(i_wdata) & CTRL_MASK));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    property p_aux_gate;
        @(posedge i_sys_clk) disable iff (!i_resetn)
            (i_aux_output_config_param != AUX_CFG_BUS) |-> !o_auxiliary_output;
    endproperty
    a_aux_gate: assert property (p_aux_gate) else $error("aux output without bus config");

    property p_power_en;
        @(posedge i_sys_clk) disable iff (!i_resetn)
            !ctrl[CB_PWR_EN] |-> !(o_power_up || o_power_down);
    endproperty
    a_power_en: assert property (p_power_en) else $error("power step without enable");

    property p_fan_count;
        @(posedge i_sys_clk) disable iff (!i_resetn)
            (fan_sync && !fan_prev) |=> (fan_count == $past(fan_count) + 32'h0000_0001);
    endproperty
    a_fan_count: assert property (p_fan_count) else $error("fan edge not counted");

    property p_temp_read;
        @(posedge i_sys_clk) disable iff (!i_resetn)
            (i_req && i_func == FC_READ_INPUT && i_addr == ADDR_TEMP)
                |=> (o_rdata == {8'h00, 8'($past(i_temp_celsius) + TEMP_OFFSET)});
    endproperty
    a_temp_read: assert property (p_temp_read) else $error("temperature read wrong");

    property p_spare_zero;
        @(posedge i_sys_clk) disable iff (!i_resetn)
            (i_req && i_func == FC_READ_INPUT && i_addr == ADDR_SPARE) |=> (o_rdata == 16'h0000 && !o_exc);
    endproperty
    a_spare_zero: assert property (p_spare_zero) else $error("spare register not zero");

    property p_serial_hi;
        @(posedge i_sys_clk) disable iff (!i_resetn)
            (i_req && i_func == FC_READ_INPUT && i_addr == ADDR_SERIAL_HI && i_lockout)
                |=> (o_rdata[15:8] == 8'h00);
    endproperty
    a_serial_hi: assert property (p_serial_hi) else $error("serial top byte shown in lockout");

    property p_warn;
        @(posedge i_sys_clk) disable iff (!i_resetn) (i_req && i_func == FC_READ_INPUT && i_addr == ADDR_IN_FUNC)
            |=> (o_rdata[10] == ($past(i_temp_celsius) > TEMP_WARN_C));
    endproperty
    a_warn: assert property (p_warn) else $error("temperature warning wrong");

    property p_di_read;
        (i_req && i_func == FC_READ_DISCRETE && i_addr < 16'(DI_BITS))
            |=> (o_rdata == {15'h0000, $past(di_sync[i_addr[1:0]])});
    endproperty
    a_di_read: assert property (p_di_read)
        else $error("discrete read wrong");

    property p_bad_reg_addr;
        (i_req && i_func == FC_WRITE_REG && i_addr > ADDR_SETPOINT)
            |=> (o_exc && o_exc_code == EXC_ILLEGAL_ADDR);
    endproperty
    a_bad_reg_addr: assert property (p_bad_reg_addr)
        else $error("bad address not refused");

    // a refused access is answered but never stored
    property p_refused_keep;
        (i_req && !(func_ok && addr_ok))
            |=> ($stable(ctrl) && $stable(setpoint));
    endproperty
    a_refused_keep: assert property (p_refused_keep)
        else $error("refused write stored");

    property p_setpoint_write;
        (i_req && i_func == FC_WRITE_MULTI && i_addr == ADDR_SETPOINT)
            |=> (setpoint == $past(i_wdata));
    endproperty
    a_setpoint_write: assert property (p_setpoint_write)
        else $error("setpoint write lost");

    property p_abs_gate;
        !o_abs_enable |-> (o_abs_setpoint == 16'h0000);
    endproperty
    a_abs_gate: assert property (p_abs_gate)
        else $error("setpoint shown without bit 11");

    property p_err_read;
        (i_req && i_func == FC_READ_INPUT && i_addr == ADDR_ERR_STATE)
            |=> (o_rdata == {8'h00, $past(i_error_state)});
    endproperty
    a_err_read: assert property (p_err_read)
        else $error("error state read wrong");

    property p_status_lock;
        (i_req && i_func == FC_READ_INPUT && i_addr == ADDR_IN_FUNC && i_lockout)
            |=> (!o_rdata[9] && o_rdata[15:13] == 3'b000);
    endproperty
    a_status_lock: assert property (p_status_lock)
        else $error("status bits shown in lockout");

    // outputs rest at zero so a late sample cannot read stale data
    property p_idle_quiet;
        !i_req |=> (!o_ack && !o_exc && o_exc_code == 8'h00 && o_rdata == 16'h0000);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("answer without request");

    property p_coil_on;
        (i_req && i_func == FC_WRITE_COIL && i_wdata == COIL_ON && i_addr < 16'(REG_DW))
            |=> ((ctrl & coil_mask($past(i_addr))) == (CTRL_MASK & coil_mask($past(i_addr))));
    endproperty
    a_coil_on: assert property (p_coil_on)
        else $error("coil on not stored");

    property p_power_hold;
        (ctrl[CB_PWR_UP] && ctrl[CB_PWR_DN]) |-> !(o_power_up || o_power_down);
    endproperty
    a_power_hold: assert property (p_power_hold)
        else $error("power step on double command");

    property p_cv_coil;
        @(posedge i_sys_clk) disable iff (!i_resetn) i_req && i_func == FC_WRITE_COIL && !o_exc;
    endproperty
    c_cv_coil: cover property (p_cv_coil);

    property p_cv_di;
        @(posedge i_sys_clk) disable iff (!i_resetn) i_req && i_func == FC_READ_DISCRETE ##1 o_rdata[0];
    endproperty
    c_cv_di: cover property (p_cv_di);

    property p_cv_abs;
        @(posedge i_sys_clk) disable iff (!i_resetn) o_abs_enable && o_abs_setpoint != 16'h0000;
    endproperty
    c_cv_abs: cover property (p_cv_abs);
endmodule

// >>> sim/bfrm_master_model.sv
// bfrm_master_model: behavioural modbus master issuing register strobes
// assumes the register bank answers one cycle after each taken request
`timescale 1ns/10ps
module bfrm_master_model (
    input  wire logic        i_sys_clk,
    output logic             o_req,
    output logic [7:0]       o_func,
    output logic [15:0]      o_addr,
    output logic [15:0]      o_wdata,
    input  wire logic        i_ack,
    input  wire logic        i_exc,
    input  wire logic [7:0]  i_exc_code,
    input  wire logic [15:0] i_rdata
);
    initial begin
        o_req = 1'b0;
        o_func = 8'h00;
        o_addr = 16'hFFFF;
        o_wdata = 16'hFFFF;
    end

    // stall adds idle cycles so the bank also sees a slow master
    task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d, input int stall,
                        output logic ack, output logic exc, output logic [7:0] code, output logic [15:0] rd);
        repeat (stall) @(negedge i_sys_clk);
        @(negedge i_sys_clk);
        o_req = 1'b1;
        o_func = f; // only 02/04 reads and 05/06/10 writes are legal
        o_addr = a;
        o_wdata = d;
        // taken at the next rising edge; the answer stands until the one after
        @(negedge i_sys_clk);
        ack = i_ack;
        exc = i_exc;
        code = i_exc_code;
        rd = i_rdata;
        o_req = 1'b0;
        // released lines show the inverse so stale values never look valid
        o_addr = ~a;
        o_wdata = ~d;
    endtask
endmodule

// >>> sim/burner_fieldbus_register_map_tb_top.sv
// burner_fieldbus_register_map_tb_top: self-checking bench for the register bank
// assumes bfrm_pkg constants and the master model drive all register traffic
`timescale 1ns/10ps
module burner_fieldbus_register_map_tb_top;
    import bfrm_pkg::*;
    logic i_sys_clk = 1'b0, i_resetn = 1'b0, req, ack, exc, lock = 1'b0, awc = 1'b0, awp = 1'b0, air2 = 1'b0;
    logic fan = 1'b0, abs_en, pup, pdn, heat, step, unlk, cool, mainb, start, aux;
    logic [7:0] func, ecode, err = 8'h00, funcs = 8'h00, temp = 8'h19;
    logic [15:0] addr, wdata, rdata, ctrl, sp;
    logic [3:0] cfg = 4'h8, hin = 4'h0;
    int failures = 0, samples_checked = 0;
    logic [15:0] cmd_list [6] = '{16'h0101, 16'h0301, 16'h0501, 16'h0701, 16'h0276, 16'h0E7F};

    always #12.5 i_sys_clk = ~i_sys_clk;

    bfrm_master_model u_master (.i_sys_clk(i_sys_clk), .o_req(req), .o_func(func), .o_addr(addr),
        .o_wdata(wdata), .i_ack(ack), .i_exc(exc), .i_exc_code(ecode), .i_rdata(rdata));

    bfrm_regs dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_req(req), .i_func(func), .i_addr(addr),
        .i_wdata(wdata), .o_ack(ack), .o_exc(exc), .o_exc_code(ecode), .o_rdata(rdata), .i_lockout(lock),
        .i_error_state(err), .i_input_funcs(funcs), .i_air_wrong_cool(awc), .i_air_wrong_purge(awp),
        .i_second_air_pressure_input(air2), .i_temp_celsius(temp), .i_aux_output_config_param(cfg),
        .i_heat_inputs(hin), .i_cooling_fan_output(fan), .o_heat_request(heat), .o_step_or_purge(step),
        .o_remote_unlock(unlk), .o_cooling_on(cool), .o_main_burner_on(mainb), .o_start_release(start),
        .o_auxiliary_output(aux), .o_power_up(pup), .o_power_down(pdn), .o_abs_enable(abs_en),
        .o_abs_setpoint(sp));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic acc(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d, input logic [15:0] exp,
                       input logic [7:0] code);
        logic k, e;
        logic [7:0] c;
        logic [15:0] r;
        u_master.xfer(f, a, d, a[0] ? 1 : 0, k, e, c, r);
        check("ack", {15'h0, k}, 16'h0001);
        check("exception", {15'h0, e}, {15'h0, code != 8'h00});
        check("exception code", {8'h00, c}, {8'h00, code});
        check("read data", r, exp);
    endtask

    function automatic logic [15:0] exp_outs(input logic [15:0] c);
        return {4'h0, c[11], c[8] & c[10] & ~c[9], c[8] & c[9] & ~c[10], 2'b00, c[6:4],
                c[3] & (cfg == AUX_CFG_BUS), c[2:0]};
    endfunction

    function automatic logic [15:0] outs();
        return {4'h0, abs_en, pdn, pup, 2'b00, start, mainb, cool, aux, unlk, step, heat};
    endfunction

    function automatic logic [15:0] in_status(input logic aux_exp);
        return {3'b000, awp, air2, temp > TEMP_WARN_C, aux_exp & ~lock, awc, funcs};
    endfunction

    initial begin
        #(25 * 20000);
        failures++;
        stop_test();
    end

    initial begin
        repeat (5) @(negedge i_sys_clk);
        i_resetn = 1'b1;
        check("outputs after reset", outs(), 16'h0000);
        check("setpoint after reset", sp, 16'h0000);
        err = 8'h2C;
        funcs = 8'hA5;
        awc = 1'b1;
        air2 = 1'b1;
        hin = 4'hA;
        repeat (8) @(negedge i_sys_clk);
        acc(FC_READ_INPUT, ADDR_SERIAL_LO, 0, SERIAL_DEFAULT[15:0], 0);
        acc(FC_READ_INPUT, ADDR_SERIAL_HI, 0, SERIAL_DEFAULT[31:16], 0);
        acc(FC_READ_INPUT, ADDR_HWART_LO, 0, HWART_DEFAULT[15:0], 0);
        acc(FC_READ_INPUT, ADDR_HWART_HI, 0, {HWREV_DEFAULT, HWART_DEFAULT[23:16]}, 0);
        acc(FC_READ_INPUT, ADDR_ART_LO, 0, ART_DEFAULT[15:0], 0);
        acc(FC_READ_INPUT, ADDR_ART_HI, 0, {ARTREV_DEFAULT, ART_DEFAULT[23:16]}, 0);
        acc(FC_READ_INPUT, ADDR_ERR_STATE, 0, {8'h00, err}, 0);
        acc(FC_READ_INPUT, ADDR_SPARE, 0, 16'h0000, 0);
        acc(FC_READ_INPUT, ADDR_IN_FUNC, 0, in_status(1'b0), 0);
        acc(FC_READ_INPUT, ADDR_TEMP, 0, 16'h004B, 0);
        $display("test identity done");
        for (int t = 82; t < 84; t++) begin
            temp = t[7:0];
            acc(FC_READ_INPUT, ADDR_IN_FUNC, 0, in_status(1'b0), 0);
            acc(FC_READ_INPUT, ADDR_TEMP, 0, {8'h00, temp + TEMP_OFFSET}, 0);
        end
        $display("test temperature done");
        foreach (cmd_list[i]) begin
            ctrl = cmd_list[i];
            acc(i[0] ? FC_WRITE_MULTI : FC_WRITE_REG, ADDR_CTRL, ctrl, 16'h0000, 0);
            check("command outputs", outs(), exp_outs(ctrl));
        end
        acc(FC_WRITE_REG, ADDR_CTRL, 16'h0000, 16'h0000, 0);
        for (int b = 0; b < 12; b++) begin
            acc(FC_WRITE_COIL, b[15:0], COIL_ON, 16'h0000, 0);
            check("coil on", outs(), exp_outs(16'h0001 << b));
            acc(FC_WRITE_COIL, b[15:0], COIL_OFF, 16'h0000, 0);
            check("coil off", outs(), 16'h0000);
        end
        cfg = 4'h7;
        acc(FC_WRITE_REG, ADDR_CTRL, 16'h0008, 16'h0000, 0);
        check("aux without bus config", outs(), 16'h0000);
        cfg = 4'h8;
        @(negedge i_sys_clk);
        check("aux with bus config", outs(), 16'h0008);
        {awc, air2, awp, funcs} = 11'h15A;
        acc(FC_READ_INPUT, ADDR_IN_FUNC, 0, in_status(1'b1), 0);
        $display("test commands done");
        acc(FC_WRITE_MULTI, ADDR_SETPOINT, 16'h00C8, 16'h0000, 0);
        check("setpoint gated", sp, 16'h0000);
        acc(FC_WRITE_REG, ADDR_CTRL, 16'h0808, 16'h0000, 0);
        check("absolute setpoint", sp, 16'h00C8);
        lock = 1'b1;
        acc(FC_READ_INPUT, ADDR_IN_FUNC, 0, in_status(1'b1), 0);
        acc(FC_READ_INPUT, ADDR_SERIAL_HI, 0, {8'h00, SERIAL_DEFAULT[23:16]}, 0);
        acc(FC_READ_INPUT, ADDR_ERR_STATE, 0, {8'h00, err}, 0);
        lock = 1'b0;
        $display("test setpoint and lockout done");
        acc(8'h03, ADDR_CTRL, 0, 16'h0000, EXC_ILLEGAL_FUNC);
        acc(FC_READ_INPUT, 16'h0001, 0, 16'h0000, EXC_ILLEGAL_ADDR);
        acc(FC_READ_DISCRETE, 16'h0004, 0, 16'h0000, EXC_ILLEGAL_ADDR);
        acc(FC_WRITE_COIL, 16'h0010, COIL_ON, 16'h0000, EXC_ILLEGAL_ADDR);
        acc(FC_WRITE_COIL, 16'h0000, 16'h1234, 16'h0000, EXC_ILLEGAL_ADDR);
        acc(FC_WRITE_REG, 16'h0002, 16'h0001, 16'h0000, EXC_ILLEGAL_ADDR);
        check("refused writes leave outputs", outs(), exp_outs(16'h0808));
        $display("test refusals done");
        acc(FC_READ_INPUT, ADDR_HW_INPUTS, 0, {12'h000, hin}, 0);
        for (int n = 0; n < DI_BITS; n++) begin
            acc(FC_READ_DISCRETE, n[15:0], 0, {15'h0000, hin[n]}, 0);
        end
        repeat (3) begin
            fan = 1'b1;
            repeat (8) @(negedge i_sys_clk);
            fan = 1'b0;
            repeat (8) @(negedge i_sys_clk);
        end
        acc(FC_READ_INPUT, ADDR_FAN_LO, 0, 16'h0003, 0);
        acc(FC_READ_INPUT, ADDR_FAN_HI, 0, 16'h0000, 0);
        $display("test inputs and counter done");
        stop_test();
    end
endmodule
